// file: banked_data_memory_defines.svh
// Offsets, field positions and reset values of the banked data memory
`ifndef BANKED_DATA_MEMORY_DEFINES_SVH
`define BANKED_DATA_MEMORY_DEFINES_SVH

`define OFS_INDIRECT_DATA_WINDOW 7'h00
`define OFS_TIMER_ZERO_COUNT 7'h01
`define OFS_PROGRAM_COUNTER_LOW 7'h02
`define OFS_CORE_STATUS_FLAGS 7'h03
`define OFS_INDIRECT_ADDRESS_POINTER 7'h04
`define OFS_PORT_A_PINS 7'h05
`define OFS_PORT_B_PINS 7'h06
`define OFS_PORT_C_PINS 7'h07
`define OFS_PORT_D_PINS 7'h08
`define OFS_PORT_E_PINS 7'h09
`define OFS_PROGRAM_COUNTER_HIGH_BUFFER 7'h0a
`define OFS_INTERRUPT_CONTROL_FLAGS 7'h0b
`define OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE 7'h0c
`define OFS_SFR_LAST 7'h1f
`define OFS_GPR_FIRST 7'h20
`define OFS_BANK_LAST 7'h7f

`define BIT_BANK_SELECT_HIGH 6
`define BIT_BANK_SELECT_LOW 5
`define BIT_INDIRECT_BANK 7

`define RST_PROGRAM_COUNTER_LOW 8'h00
`define RST_PROGRAM_COUNTER_HIGH_BUFFER 8'h00
`define RST_CORE_STATUS_FLAGS 8'h18
`define RST_PERIPHERAL_INTERRUPT_FLAGS_ONE 8'h00
`define RST_GENERIC 8'h00

`define MASK_PORT_A 8'h3f
`define MASK_PORT_E 8'h07
`define MASK_PC_HIGH_BUFFER 8'h1f

`endif

// file: banked_data_memory_pkg.sv
// Types shared by the banked data memory files
package banked_data_memory_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] bank_t;
    typedef logic [6:0] offset_t;
    typedef logic [8:0] data_addr_t;
    typedef enum logic [1:0] {
        REGION_NONE,
        REGION_SFR,
        REGION_GPR
    } region_e;
endpackage

// file: gpr_static_ram.sv
// General purpose static RAM, flip-flop storage addressed by index
`timescale 1ns/1ps
module gpr_static_ram #(
    parameter int DEPTH = 384,
    parameter int AW = 9
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [DEPTH];

    // Static RAM keeps no reset value, as the core expects
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // Asynchronous read; the top registers the result
    always_comb begin
        rd_data = mem_q[rd_idx];
    end
endmodule

// file: banked_data_memory.sv
// Banked data memory with special function register map for an 8-bit core
//
// Operation
// - Bank select comes from status bit 6 (high) and bit 5 (low).
// - The two bank bits form a binary bank number 0 to 3.
// - Every bank spans offsets 00h to 7Fh, 128 bytes.
// - Special function registers occupy the lowest offsets of each bank.
// - General purpose static RAM sits above the special function registers.
// - Every bank holds special function register locations.
// - Selected registers are mirrored so several banks reach one register.
// - Accesses go direct by instruction address or indirect through the pointer.
// - Special function registers other than the window and timer count are held storage, split into core and peripheral.
// - Window, status, pointer and counter registers answer in every bank.
// - Unimplemented locations and bits read as zero.
`timescale 1ns/1ps
`include "banked_data_memory_defines.svh"
module banked_data_memory #(
    parameter int GPR_BYTES_PER_BANK = 96
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire banked_data_memory_pkg::offset_t acc_offset,
    input wire banked_data_memory_pkg::byte_t acc_wdata,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [7:0] port_d_in,
    input wire logic [7:0] port_e_in,
    input wire banked_data_memory_pkg::byte_t timer_zero_in,
    output banked_data_memory_pkg::byte_t acc_rdata,
    output logic acc_rvalid,
    output banked_data_memory_pkg::byte_t status_q_out,
    output banked_data_memory_pkg::byte_t pc_low_out,
    output banked_data_memory_pkg::byte_t pc_high_buffer_out,
    output banked_data_memory_pkg::byte_t port_a_latch,
    output banked_data_memory_pkg::byte_t port_b_latch,
    output banked_data_memory_pkg::byte_t port_c_latch,
    output banked_data_memory_pkg::byte_t port_d_latch,
    output banked_data_memory_pkg::byte_t port_e_latch,
    output banked_data_memory_pkg::byte_t timer_zero_load,
    output logic timer_zero_load_en,
    output banked_data_memory_pkg::byte_t interrupt_control_out,
    output banked_data_memory_pkg::byte_t peripheral_flags_out
);
    import banked_data_memory_pkg::*;

    localparam int GPR_DEPTH = 4 * GPR_BYTES_PER_BANK;
    localparam int GPR_AW = $clog2(GPR_DEPTH);
    localparam offset_t GPR_BASE = `OFS_GPR_FIRST;

    byte_t status_q, pointer_q, pc_low_q, pch_buf_q, int_ctrl_q, periph_flags_q;
    byte_t port_a_q, port_b_q, port_c_q, port_d_q, port_e_q;
    byte_t tmr_load_q, rdata_q;
    logic tmr_load_en_q, rvalid_q;
    bank_t bank_sel;
    offset_t eff_offset;
    bank_t eff_bank;
    data_addr_t eff_addr;
    region_e region;
    logic is_common;
    logic [GPR_AW-1:0] gpr_idx;
    byte_t gpr_rdata;
    byte_t sfr_rdata;
    logic wr_sfr, wr_gpr;

    // Bank bits come straight from the held status register
    assign bank_sel = {status_q[`BIT_BANK_SELECT_HIGH], status_q[`BIT_BANK_SELECT_LOW]};

    // Offset 00h redirects through the pointer; status bit 7 picks the bank pair, pointer bit 7 the bank within it
    always_comb begin
        if (acc_offset == `OFS_INDIRECT_DATA_WINDOW) begin
            eff_offset = pointer_q[6:0];
            eff_bank = {status_q[`BIT_INDIRECT_BANK], pointer_q[7]};
        end else begin
            eff_offset = acc_offset;
            eff_bank = bank_sel;
        end
    end

    assign eff_addr = {eff_bank, eff_offset};

    // Region split: registers low, static RAM above them, in every bank
    always_comb begin
        if (eff_offset <= `OFS_SFR_LAST) begin
            region = REGION_SFR;
        end else if (eff_offset <= `OFS_BANK_LAST) begin
            region = REGION_GPR;
        end else begin
            region = REGION_NONE;
        end
    end

    // Core registers that answer at their offset whatever bank is chosen
    always_comb begin
        case (eff_offset)
            `OFS_PROGRAM_COUNTER_LOW, `OFS_CORE_STATUS_FLAGS, `OFS_INDIRECT_ADDRESS_POINTER,
            `OFS_PROGRAM_COUNTER_HIGH_BUFFER, `OFS_INTERRUPT_CONTROL_FLAGS: is_common = 1'b1;
            default: is_common = 1'b0;
        endcase
    end

    // A redirected access to 00h again reaches nothing; it never writes
    assign wr_sfr = acc_valid && acc_write && region == REGION_SFR && eff_offset != `OFS_INDIRECT_DATA_WINDOW
        && (is_common || eff_bank == 2'b00);
    assign wr_gpr = acc_valid && acc_write && region == REGION_GPR;

    // Static RAM index: bank times per-bank size plus offset above the registers
    assign gpr_idx = GPR_AW'(int'(eff_bank) * GPR_BYTES_PER_BANK + int'(eff_offset - GPR_BASE));

    gpr_static_ram #(
        .DEPTH(GPR_DEPTH),
        .AW(GPR_AW)
    ) u_gpr (
        .sys_clk(sys_clk),
        .wr_en(wr_gpr),
        .wr_idx(gpr_idx),
        .wr_data(acc_wdata),
        .rd_idx(gpr_idx),
        .rd_data(gpr_rdata)
    );

    // Core group registers; status bits 2:0 are core flags kept as written, bits 4:3 hold their value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_q <= `RST_CORE_STATUS_FLAGS;
            pointer_q <= `RST_GENERIC;
            pc_low_q <= `RST_PROGRAM_COUNTER_LOW;
            pch_buf_q <= `RST_PROGRAM_COUNTER_HIGH_BUFFER;
            int_ctrl_q <= `RST_GENERIC;
        end else if (wr_sfr) begin
            case (eff_offset)
                `OFS_CORE_STATUS_FLAGS: status_q <= {acc_wdata[7:5], status_q[4:3], acc_wdata[2:0]};
                `OFS_INDIRECT_ADDRESS_POINTER: pointer_q <= acc_wdata;
                `OFS_PROGRAM_COUNTER_LOW: pc_low_q <= acc_wdata;
                `OFS_PROGRAM_COUNTER_HIGH_BUFFER: pch_buf_q <= acc_wdata & `MASK_PC_HIGH_BUFFER;
                `OFS_INTERRUPT_CONTROL_FLAGS: int_ctrl_q <= acc_wdata;
                default: ;
            endcase
        end
    end

    // Peripheral group registers, bank 0 only; ports keep their data latches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_a_q <= `RST_GENERIC;
            port_b_q <= `RST_GENERIC;
            port_c_q <= `RST_GENERIC;
            port_d_q <= `RST_GENERIC;
            port_e_q <= `RST_GENERIC;
            periph_flags_q <= `RST_PERIPHERAL_INTERRUPT_FLAGS_ONE;
        end else if (wr_sfr) begin
            case (eff_offset)
                `OFS_PORT_A_PINS: port_a_q <= acc_wdata & `MASK_PORT_A;
                `OFS_PORT_B_PINS: port_b_q <= acc_wdata;
                `OFS_PORT_C_PINS: port_c_q <= acc_wdata;
                `OFS_PORT_D_PINS: port_d_q <= acc_wdata;
                `OFS_PORT_E_PINS: port_e_q <= acc_wdata & `MASK_PORT_E;
                `OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE: periph_flags_q <= acc_wdata;
                default: ;
            endcase
        end
    end

    // Timer writes pass out as a one-cycle load strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tmr_load_q <= `RST_GENERIC;
            tmr_load_en_q <= 1'b0;
        end else begin
            tmr_load_en_q <= wr_sfr && eff_offset == `OFS_TIMER_ZERO_COUNT;
            if (wr_sfr && eff_offset == `OFS_TIMER_ZERO_COUNT) begin
                tmr_load_q <= acc_wdata;
            end
        end
    end

    // Register read mux; ports read the pins, holes read zero
    always_comb begin
        sfr_rdata = `RST_GENERIC;
        if (is_common || eff_bank == 2'b00) begin
            case (eff_offset)
                `OFS_TIMER_ZERO_COUNT: sfr_rdata = timer_zero_in;
                `OFS_PROGRAM_COUNTER_LOW: sfr_rdata = pc_low_q;
                `OFS_CORE_STATUS_FLAGS: sfr_rdata = status_q;
                `OFS_INDIRECT_ADDRESS_POINTER: sfr_rdata = pointer_q;
                `OFS_PORT_A_PINS: sfr_rdata = port_a_in & `MASK_PORT_A;
                `OFS_PORT_B_PINS: sfr_rdata = port_b_in;
                `OFS_PORT_C_PINS: sfr_rdata = port_c_in;
                `OFS_PORT_D_PINS: sfr_rdata = port_d_in;
                `OFS_PORT_E_PINS: sfr_rdata = port_e_in & `MASK_PORT_E;
                `OFS_PROGRAM_COUNTER_HIGH_BUFFER: sfr_rdata = pch_buf_q;
                `OFS_INTERRUPT_CONTROL_FLAGS: sfr_rdata = int_ctrl_q;
                `OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE: sfr_rdata = periph_flags_q;
                default: sfr_rdata = `RST_GENERIC;
            endcase
        end
    end

    // Read answer registered one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= `RST_GENERIC;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= acc_valid && !acc_write;
            if (acc_valid && !acc_write) begin
                case (region)
                    REGION_SFR: rdata_q <= sfr_rdata;
                    REGION_GPR: rdata_q <= gpr_rdata;
                    default: rdata_q <= `RST_GENERIC;
                endcase
            end
        end
    end

    assign acc_rdata = rdata_q;
    assign acc_rvalid = rvalid_q;
    assign status_q_out = status_q;
    assign pc_low_out = pc_low_q;
    assign pc_high_buffer_out = pch_buf_q;
    assign port_a_latch = port_a_q;
    assign port_b_latch = port_b_q;
    assign port_c_latch = port_c_q;
    assign port_d_latch = port_d_q;
    assign port_e_latch = port_e_q;
    assign timer_zero_load = tmr_load_q;
    assign timer_zero_load_en = tmr_load_en_q;
    assign interrupt_control_out = int_ctrl_q;
    assign peripheral_flags_out = periph_flags_q;

    // Status write in bank 2 lands on the same register seen from bank 0
    chk_status_mirror: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_CORE_STATUS_FLAGS |=> status_q[7:5] == $past(acc_wdata[7:5]))
        else $error("status write did not reach the shared register");

    chk_pointer_write: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_INDIRECT_ADDRESS_POINTER |=> pointer_q == $past(acc_wdata))
        else $error("pointer write lost");

    chk_window_read: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && !acc_write && acc_offset == `OFS_INDIRECT_DATA_WINDOW
        && pointer_q[6:0] == `OFS_INDIRECT_DATA_WINDOW |=> acc_rdata == 8'h00)
        else $error("window self read not zero");

    chk_hole_read: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && !acc_write && acc_offset > `OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE
        && acc_offset <= `OFS_SFR_LAST |=> acc_rdata == 8'h00)
        else $error("unimplemented location read not zero");

    chk_bank_decode: assert property (@(posedge sys_clk) disable iff (rst)
        acc_offset != `OFS_INDIRECT_DATA_WINDOW |-> eff_addr == {status_q[6], status_q[5], acc_offset})
        else $error("direct address formed wrongly");

    chk_region_split: assert property (@(posedge sys_clk) disable iff (rst)
        (eff_offset < GPR_BASE) == (region == REGION_SFR))
        else $error("register and ram split misplaced");

    chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && !acc_write |=> acc_rvalid ##1 !acc_rvalid || $past(acc_valid && !acc_write))
        else $error("read answer timing wrong");

    chk_port_a_pins_bits: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && !acc_write && acc_offset == `OFS_PORT_A_PINS && bank_sel == 2'b00
        |=> acc_rdata[7:6] == 2'b00 && acc_rdata[5:0] == $past(port_a_in[5:0]))
        else $error("port a read wrong");

    // High buffer keeps only its five counter bits; a stray bit would corrupt a jump
    chk_pch_bits: assert property (@(posedge sys_clk) disable iff (rst)
        pc_high_buffer_out[7:5] == 3'h0)
        else $error("high buffer unused bits set");

    // Port E latch keeps only its three pin bits
    chk_port_e_bits: assert property (@(posedge sys_clk) disable iff (rst)
        port_e_latch[7:3] == 5'h00)
        else $error("port e unused bits set");

    // Peripheral offsets outside bank 0 reach nothing
    chk_periph_bank: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_PERIPHERAL_INTERRUPT_FLAGS_ONE && bank_sel != 2'h0
        |=> $stable(periph_flags_q))
        else $error("peripheral write leaked out of bank 0");

    // Timer write from bank 0 leaves as a one-cycle load carrying its data
    chk_timer_load: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_TIMER_ZERO_COUNT && bank_sel == 2'h0
        |=> timer_zero_load_en && timer_zero_load == $past(acc_wdata))
        else $error("timer load strobe wrong");

    // Control flags are shared, so a write from any bank lands
    chk_control_mirror: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_INTERRUPT_CONTROL_FLAGS |=> int_ctrl_q == $past(acc_wdata))
        else $error("control flags write lost");

    // Counter low byte is shared, so a write from any bank lands
    chk_pc_low_write: assert property (@(posedge sys_clk) disable iff (rst)
        acc_valid && acc_write && acc_offset == `OFS_PROGRAM_COUNTER_LOW |=> pc_low_q == $past(acc_wdata))
        else $error("counter low write lost");
endmodule

// file: core_access_model.sv
// Behavioural processor core that issues direct and indirect data memory accesses
`timescale 1ns/1ps
module core_access_model (
    input wire logic sys_clk,
    output logic acc_valid,
    output logic acc_write,
    output banked_data_memory_pkg::offset_t acc_offset,
    output banked_data_memory_pkg::byte_t acc_wdata,
    input wire logic acc_rvalid,
    input wire banked_data_memory_pkg::byte_t acc_rdata
);
    import banked_data_memory_pkg::*;

    // Idle request lines at time zero
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_offset = 7'h00;
        acc_wdata = 8'h00;
    end

    // One write, held for one taking edge; data inverted after so stale data never looks valid
    task automatic wr(input offset_t ofs, input byte_t data);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_write <= 1'b1;
        acc_offset <= ofs; // Direct offset, or 00h for the pointer path
        acc_wdata <= data;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        acc_wdata <= ~data;
    endtask

    // One read; the answer stands for one cycle after the taking edge
    task automatic rd(input offset_t ofs, output byte_t data, output logic ok);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_write <= 1'b0;
        acc_offset <= ofs;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        #1;
        ok = acc_rvalid;
        data = acc_rdata;
    endtask
endmodule

// file: tb_top.sv
// Self-checking testbench for the banked data memory
`timescale 1ns/1ps
module tb_top;
    import banked_data_memory_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic acc_valid, acc_write, acc_rvalid, timer_zero_load_en;
    offset_t acc_offset;
    byte_t acc_wdata, acc_rdata, status_q_out, port_b_latch, timer_zero_load;
    byte_t pc_low_out, pc_high_buffer_out, port_a_latch, port_c_latch, port_d_latch, port_e_latch;
    byte_t interrupt_control_out, peripheral_flags_out;
    logic [7:0] port_a_in = 8'hff;
    logic [7:0] port_b_in = 8'h5a;
    logic [7:0] port_c_in = 8'hc3;
    logic [7:0] port_d_in = 8'h96;
    logic [7:0] port_e_in = 8'hff;
    byte_t timer_zero_in = 8'h3c;
    int failures = 0;
    int tests_run = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    banked_data_memory i_dut (.sys_clk(sys_clk), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_offset(acc_offset), .acc_wdata(acc_wdata), .port_a_in(port_a_in), .port_b_in(port_b_in),
        .port_c_in(port_c_in), .port_d_in(port_d_in), .port_e_in(port_e_in), .timer_zero_in(timer_zero_in),
        .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .status_q_out(status_q_out), .pc_low_out(pc_low_out),
        .pc_high_buffer_out(pc_high_buffer_out), .port_a_latch(port_a_latch), .port_b_latch(port_b_latch),
        .port_c_latch(port_c_latch), .port_d_latch(port_d_latch), .port_e_latch(port_e_latch),
        .timer_zero_load(timer_zero_load), .timer_zero_load_en(timer_zero_load_en),
        .interrupt_control_out(interrupt_control_out), .peripheral_flags_out(peripheral_flags_out));

    core_access_model i_core (.sys_clk(sys_clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_offset(acc_offset), .acc_wdata(acc_wdata), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata));

    // Case equality so an unknown never passes
    task automatic chk(input byte_t got, input byte_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Read one offset and judge both the valid pulse and the data
    task automatic rchk(input offset_t ofs, input byte_t exp);
        byte_t d;
        logic ok;
        i_core.rd(ofs, d, ok);
        chk({7'h00, ok}, 8'h01, "read valid");
        chk(d, exp, "read data");
    endtask

    // Status bits 6:5 pick the bank; the other writable bits are left clear
    task automatic sel(input bank_t b);
        i_core.wr(7'h03, {1'b0, b, 5'h00});
    endtask

    task automatic t_reset();
        chk(status_q_out, 8'h18, "status reset");
        rchk(7'h03, 8'h18);
        rchk(7'h0a, 8'h00);
        rchk(7'h02, 8'h00);
        $display("test reset done");
    endtask

    // Distinct bytes at both ends of each bank's RAM prove four separate banks
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            sel(2'(b));
            #1 chk(status_q_out, {1'b0, 2'(b), 5'h18}, "bank bits");
            i_core.wr(7'h20, 8'(8'h40 + b));
            i_core.wr(7'h7f, 8'(8'h80 + b));
        end
        for (int b = 3; b >= 0; b--) begin
            sel(2'(b));
            rchk(7'h20, 8'(8'h40 + b));
            rchk(7'h7f, 8'(8'h80 + b));
        end
        $display("test banks done");
    endtask

    task automatic t_map();
        sel(2'd3);
        i_core.wr(7'h04, 8'h5e);
        sel(2'd0);
        rchk(7'h04, 8'h5e);
        rchk(7'h05, 8'h3f);
        rchk(7'h09, 8'h07);
        rchk(7'h06, 8'h5a);
        rchk(7'h0d, 8'h00);
        i_core.wr(7'h06, 8'ha5);
        #1 chk(port_b_latch, 8'ha5, "port latch");
        sel(2'd2);
        rchk(7'h03, 8'h58);
        sel(2'd1);
        rchk(7'h05, 8'h00);
        $display("test map done");
    endtask

    // Pointer a0h with status bit 7 clear lands on bank 1 offset 20h
    task automatic t_indirect();
        sel(2'd0);
        i_core.wr(7'h04, 8'ha0);
        i_core.wr(7'h00, 8'h77);
        rchk(7'h00, 8'h77);
        sel(2'd1);
        rchk(7'h20, 8'h77);
        i_core.wr(7'h04, 8'h00);
        i_core.wr(7'h00, 8'hff); // Dropped: window pointing at itself has no storage
        rchk(7'h04, 8'h00);
        rchk(7'h00, 8'h00);
        $display("test indirect done");
    endtask

    task automatic t_timer();
        sel(2'd0);
        i_core.wr(7'h01, 8'h9b);
        #1 chk({7'h00, timer_zero_load_en}, 8'h01, "load pulse");
        chk(timer_zero_load, 8'h9b, "load data");
        rchk(7'h01, 8'h3c);
        $display("test timer done");
    endtask

    // Status bit 7 lifts the pointer into banks 2 and 3, reusing bytes left by the bank test
    task automatic t_high();
        i_core.wr(7'h03, 8'h80);
        #1 chk(status_q_out, 8'h98, "indirect bank bit");
        i_core.wr(7'h04, 8'ha0);
        rchk(7'h00, 8'h43);
        i_core.wr(7'h04, 8'h7f);
        rchk(7'h00, 8'h82);
        sel(2'd0);
        $display("test high banks done");
    endtask

    // Masked bits read zero; peripherals live in bank 0, shared core registers everywhere
    task automatic t_bits();
        sel(2'd1);
        i_core.wr(7'h0a, 8'hff);
        #1 chk(pc_high_buffer_out, 8'h1f, "high buffer bits");
        i_core.wr(7'h0b, 8'hc5);
        #1 chk(interrupt_control_out, 8'hc5, "control mirror");
        i_core.wr(7'h0c, 8'h81);
        i_core.wr(7'h09, 8'hff);
        #1 chk(port_e_latch, 8'h00, "bank 1 port write");
        chk(peripheral_flags_out, 8'h00, "bank 1 flags write");
        sel(2'd0);
        rchk(7'h0c, 8'h00);
        rchk(7'h0a, 8'h1f);
        rchk(7'h0b, 8'hc5);
        i_core.wr(7'h0c, 8'h81);
        #1 chk(peripheral_flags_out, 8'h81, "flags write");
        i_core.wr(7'h09, 8'hff);
        #1 chk(port_e_latch, 8'h07, "port e latch bits");
        i_core.wr(7'h07, 8'h3c);
        i_core.wr(7'h08, 8'hc3);
        #1 chk(port_c_latch, 8'h3c, "port c latch");
        chk(port_d_latch, 8'hc3, "port d latch");
        $display("test bits done");
    endtask

    // Reset in mid-run returns the held registers to their reset values
    task automatic t_rst_again();
        i_core.wr(7'h02, 8'h12);
        i_core.wr(7'h05, 8'hff);
        #1 chk(pc_low_out, 8'h12, "pc low write");
        chk(port_a_latch, 8'h3f, "port a latch bits");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk(pc_low_out, 8'h00, "pc low reset");
        chk(port_a_latch, 8'h00, "port a reset");
        chk(status_q_out, 8'h18, "status reset again");
        rchk(7'h02, 8'h00);
        $display("test second reset done");
    endtask

    // Prints the counts and verdict, then stops
    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence after 8 cycles of reset
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_banks();
        t_map();
        t_indirect();
        t_high();
        t_bits();
        t_timer();
        t_rst_again();
        end_sim();
    end

    // Watchdog well beyond the roughly 160 cycles the tests need
    initial begin
        #100000;
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
